// ===== design/pot_i2c_pkg.sv
package pot_i2c_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] ADDR_POT0 = 4'h0;
	localparam logic [3:0] ADDR_POT1 = 4'h1;
	localparam logic [3:0] ADDR_GP_FIRST = 4'h2;
	localparam logic [3:0] ADDR_GP_LAST = 4'h6;
	localparam logic [3:0] ADDR_RESERVED = 4'h7;
	localparam logic [3:0] ADDR_ACR = 4'h8;
	localparam logic [3:0] ADDR_WRAP = 4'h8;
	// ****************************************
	// Access control fields and resets
	// ****************************************
	localparam int ACR_VOL_BIT = 7;
	localparam int ACR_SHUTDOWN_CONTROL_BIT = 6;
	localparam int ACR_BUSY_BIT = 5;
	localparam logic VOL_RESET = 1'b0;
	localparam logic SHUTDOWN_CONTROL_RESET = 1'b1;
	localparam logic [7:0] WIPER_RESET = 8'h40;
	localparam logic [7:0] NV_RESET = 8'h40;
	localparam logic [7:0] GP_RESET = 8'h00;
	// ****************************************
	// Bus identity and timing
	// ****************************************
	localparam logic [3:0] ID_PREFIX = 4'ha;
	localparam int CLK_MHZ = 100;
	localparam int NV_WRITE_MS = 20;
	localparam int NV_WRITE_CYCLES = NV_WRITE_MS * 1000 * CLK_MHZ;
	localparam int POWERUP_US = 1;
	localparam int POWERUP_CYCLES = POWERUP_US * CLK_MHZ;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RECV = 3'b001,
		ST_ACK = 3'b010,
		ST_SEND = 3'b011,
		ST_MACK = 3'b100
	} bus_state_type;
	typedef enum logic [1:0] {
		PH_ID = 2'b00,
		PH_ADDR = 2'b01,
		PH_DATA = 2'b10
	} phase_type;
endpackage

// ===== design/pot_i2c_slave.sv
// Behaviour
// - Pots run only when shutdown pin high and shutdown bit one.
// - Device is always slave; master supplies clock and starts transfers.
// - Every byte is shifted most significant bit first.
// - Data changes only while clock low; else it is start or stop.
// - After power-up the data line is not driven.
// - All activity ignored until a start condition is seen.
// - Starts during power-up are ignored.
// - Stop ends every operation and returns to standby.
// - Transmitter releases data after eight bits; receiver acks ninth clock.
// - Device acks matching id, every address byte, every write data byte.
// - Id byte is 1010, strap bits, then read/write bit.
// - Write pointer increments per data byte, wraps 08h to 00h.
// - Non-volatile write starts at stop and lasts up to 20ms.
// - Device sends bytes while master acks; master ends with stop.
// - Read pointer loaded by address, increments per byte, wraps 08h.
// - Volatile bit zero targets initial values and copies to wipers.
// - Shutdown control bit resets to one.
// - While busy, writes to pots and access control are rejected.
// - Decode pots 0-1, general 2-6, reserved 7, control 8.
module pot_i2c_slave
	import pot_i2c_pkg::*;
#(
	parameter int NV_CYCLES = pot_i2c_pkg::NV_WRITE_CYCLES
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       addr_strap_bit2,
	input  wire logic       addr_strap_bit1,
	input  wire logic       addr_strap_bit0,
	input  wire logic       shutdown_n,
	output logic            pot_shutdown,
	output logic [7:0]      wiper0,
	output logic [7:0]      wiper1,
	output logic            nv_write_busy
);
	import pot_i2c_pkg::*;
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] scl_sync_reg;
	logic [2:0] sda_sync_reg;
	logic       scl_reg;
	logic       sda_reg;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
			sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
		end
	end
	// Filtered level only moves when stages 2 and 3 agree
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
		end else begin
			if (scl_sync_reg[1] == scl_sync_reg[2])
				scl_reg <= scl_sync_reg[2];
			if (sda_sync_reg[1] == sda_sync_reg[2])
				sda_reg <= sda_sync_reg[2];
		end
	end
	logic scl_prev_reg;
	logic sda_prev_reg;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_prev_reg <= scl_reg;
			sda_prev_reg <= sda_reg;
		end
	end
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_rise = scl_reg && !scl_prev_reg;
	assign scl_fall = !scl_reg && scl_prev_reg;
	assign start_det = scl_reg && scl_prev_reg && sda_prev_reg && !sda_reg;
	assign stop_det = scl_reg && scl_prev_reg && !sda_prev_reg && sda_reg;
	// ****************************************
	// Power-up hold-off
	// ****************************************
	logic [$clog2(POWERUP_CYCLES+1)-1:0] pwr_cnt_reg;
	logic powered;
	assign powered = (pwr_cnt_reg == POWERUP_CYCLES[$clog2(POWERUP_CYCLES+1)-1:0]);
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			pwr_cnt_reg <= '0;
		else if (!powered)
			pwr_cnt_reg <= pwr_cnt_reg + 1'b1;
	end
	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] nv_reg [0:6];
	logic [7:0] wiper_reg [0:1];
	logic       vol_reg;
	logic       shutdown_control_reg;
	logic [31:0] busy_cnt_reg;
	logic        nv_pending_reg;
	assign nv_write_busy = (busy_cnt_reg != 32'h0);
	assign wiper0 = wiper_reg[0];
	assign wiper1 = wiper_reg[1];
	assign pot_shutdown = !(shutdown_n && shutdown_control_reg);
	// ****************************************
	// Bus engine
	// ****************************************
	bus_state_type state_reg;
	phase_type     phase_reg;
	logic [7:0] shift_reg;
	logic [3:0] bit_cnt_reg;
	logic [3:0] ptr_reg;
	logic       ack_ok_reg;
	logic       sda_drive_reg;
	logic [7:0] rd_data;
	logic [2:0] straps;
	logic [3:0] ptr_inc;
	logic       wr_ok;
	assign straps = {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
	assign ptr_inc = (ptr_reg == ADDR_WRAP) ? 4'h0 : ptr_reg + 4'h1;
	assign wr_ok = !nv_write_busy;
	always_comb begin
		rd_data = 8'h00;
		if (ptr_reg <= ADDR_POT1) begin
			rd_data = vol_reg ? wiper_reg[ptr_reg[0]] : nv_reg[ptr_reg[2:0]];
		end else if (ptr_reg <= ADDR_GP_LAST) begin
			rd_data = nv_reg[ptr_reg[2:0]];
		end else if (ptr_reg == ADDR_ACR) begin
			rd_data = 8'h00;
			rd_data[ACR_VOL_BIT] = vol_reg;
			rd_data[ACR_SHUTDOWN_CONTROL_BIT] = shutdown_control_reg;
			rd_data[ACR_BUSY_BIT] = nv_write_busy;
		end
	end
	// Data byte just received while in write phase
	logic wr_strobe;
	logic [7:0] rx_byte;
	assign rx_byte = {shift_reg[6:0], sda_reg};
	assign wr_strobe = (state_reg == ST_RECV) && scl_rise && (bit_cnt_reg == 4'h7)
		&& (phase_reg == PH_DATA);
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			phase_reg <= PH_ID;
			shift_reg <= 8'h00;
			bit_cnt_reg <= 4'h0;
			ptr_reg <= 4'h0;
			ack_ok_reg <= 1'b0;
		end else if (stop_det) begin
			state_reg <= ST_IDLE;
		end else if (start_det && powered) begin
			state_reg <= ST_RECV;
			phase_reg <= PH_ID;
			bit_cnt_reg <= 4'h0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					bit_cnt_reg <= 4'h0;
				end
				ST_RECV: begin
					if (scl_rise) begin
						shift_reg <= rx_byte;
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (scl_fall && bit_cnt_reg == 4'h8) begin
						bit_cnt_reg <= 4'h0;
						state_reg <= ST_ACK;
						ack_ok_reg <= 1'b1;
						case (phase_reg)
							PH_ID: begin
								if (shift_reg[7:1] != {ID_PREFIX, straps}) begin
									ack_ok_reg <= 1'b0;
									state_reg <= ST_IDLE;
								end
							end
							PH_ADDR: ptr_reg <= shift_reg[3:0];
							default: ptr_reg <= ptr_inc;
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (phase_reg == PH_ID && shift_reg[0]) begin
							state_reg <= ST_SEND;
							shift_reg <= rd_data;
							phase_reg <= PH_DATA;
						end else begin
							state_reg <= ST_RECV;
							phase_reg <= (phase_reg == PH_ID) ? PH_ADDR : PH_DATA;
						end
					end
				end
				ST_SEND: begin
					if (scl_fall) begin
						shift_reg <= {shift_reg[6:0], 1'b0};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						if (bit_cnt_reg == 4'h7) begin
							state_reg <= ST_MACK;
							ptr_reg <= ptr_inc;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						ack_ok_reg <= !sda_reg;
					end else if (scl_fall) begin
						bit_cnt_reg <= 4'h0;
						if (ack_ok_reg) begin
							state_reg <= ST_SEND;
							shift_reg <= rd_data;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
	// Open-drain output: only ever pulls low, released in idle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sda_drive_reg <= 1'b0;
		end else if (stop_det || start_det) begin
			sda_drive_reg <= 1'b0;
		end else if (state_reg == ST_RECV && scl_fall && bit_cnt_reg == 4'h8) begin
			sda_drive_reg <= (phase_reg != PH_ID) ||
				(shift_reg[7:1] == {ID_PREFIX, straps});
		end else if (state_reg == ST_ACK && scl_fall) begin
			sda_drive_reg <= (phase_reg == PH_ID) && shift_reg[0] && !rd_data[7];
		end else if (state_reg == ST_SEND && scl_fall) begin
			sda_drive_reg <= (bit_cnt_reg != 4'h7) && !shift_reg[6];
		end else if (state_reg == ST_MACK && scl_fall) begin
			sda_drive_reg <= ack_ok_reg && !rd_data[7];
		end
	end
	assign sda_out = 1'b0;
	assign sda_oe = sda_drive_reg;
	// ****************************************
	// Register writes and non-volatile timer
	// ****************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			vol_reg <= VOL_RESET;
			shutdown_control_reg <= SHUTDOWN_CONTROL_RESET;
			wiper_reg[0] <= WIPER_RESET;
			wiper_reg[1] <= WIPER_RESET;
			for (int i = 0; i < 7; i++)
				nv_reg[i] <= (i < 2) ? NV_RESET : GP_RESET;
			nv_pending_reg <= 1'b0;
		end else begin
			if (stop_det)
				nv_pending_reg <= 1'b0;
			if (wr_strobe) begin
				if (ptr_reg <= ADDR_POT1) begin
					if (wr_ok) begin
						wiper_reg[ptr_reg[0]] <= rx_byte;
						if (!vol_reg) begin
							nv_reg[ptr_reg[2:0]] <= rx_byte;
							nv_pending_reg <= 1'b1;
						end
					end
				end else if (ptr_reg <= ADDR_GP_LAST) begin
					if (wr_ok) begin
						nv_reg[ptr_reg[2:0]] <= rx_byte;
						nv_pending_reg <= 1'b1;
					end
				end else if (ptr_reg == ADDR_ACR) begin
					if (wr_ok) begin
						vol_reg <= rx_byte[ACR_VOL_BIT];
						shutdown_control_reg <= rx_byte[ACR_SHUTDOWN_CONTROL_BIT];
					end
				end
			end
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			busy_cnt_reg <= 32'h0;
		else if (stop_det && nv_pending_reg)
			busy_cnt_reg <= 32'(NV_CYCLES);
		else if (busy_cnt_reg != 32'h0)
			busy_cnt_reg <= busy_cnt_reg - 32'h1;
	end
	// ****************************************
	// Checks
	// ****************************************
	chk_idle_release: assert property (@(posedge sys_clk) disable iff (rst)
		(state_reg == ST_IDLE && $past(state_reg) == ST_IDLE) |-> !sda_oe)
		else $error("data line driven in idle");
	chk_stop_standby: assert property (@(posedge sys_clk) disable iff (rst)
		stop_det |=> state_reg == ST_IDLE)
		else $error("stop did not return to standby");
	chk_nv_timer: assert property (@(posedge sys_clk) disable iff (rst)
		(stop_det && nv_pending_reg) |=> nv_write_busy)
		else $error("busy not set after stop");
	chk_shutdown_and: assert property (@(posedge sys_clk) disable iff (rst)
		pot_shutdown == !(shutdown_n && shutdown_control_reg))
		else $error("shutdown mismatch");
	chk_ptr_wrap: assert property (@(posedge sys_clk) disable iff (rst)
		(state_reg == ST_RECV && phase_reg == PH_DATA && scl_fall
		&& bit_cnt_reg == 4'h8 && ptr_reg == ADDR_WRAP) |=> ptr_reg == 4'h0)
		else $error("pointer did not wrap");
	chk_busy_reject: assert property (@(posedge sys_clk) disable iff (rst)
		(wr_strobe && nv_write_busy) |=> $stable(wiper_reg[0]) && $stable(shutdown_control_reg))
		else $error("write accepted while busy");
	chk_powerup_start: assert property (@(posedge sys_clk) disable iff (rst)
		(start_det && !powered && state_reg == ST_IDLE) |=> state_reg == ST_IDLE)
		else $error("start accepted in power-up");
	chk_bad_id: assert property (@(posedge sys_clk) disable iff (rst)
		(state_reg == ST_RECV && phase_reg == PH_ID && scl_fall && bit_cnt_reg == 4'h8
		&& shift_reg[7:1] != {ID_PREFIX, straps}) |=> !sda_oe)
		else $error("bad id acknowledged");
	cov_write: cover property (@(posedge sys_clk) disable iff (rst) wr_strobe);
	cov_read: cover property (@(posedge sys_clk) disable iff (rst)
		state_reg == ST_SEND);
	cov_busy: cover property (@(posedge sys_clk) disable iff (rst) nv_write_busy);
endmodule // pot_i2c_slave

// ===== verification/bus_master.sv
// ****************************************
// Bus master on the far side of the pins
// ****************************************
module bus_master (
	input  wire logic sys_clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_low
);
	timeunit 1ns;
	timeprecision 1ps;
	// Lines idle high; clock stands still between frames
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic q(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// Also serves as repeated start: data let go before clock rises
	task automatic start();
		sda_low = 1'b0;
		q(3);
		scl = 1'b1; // Master makes every clock
		q(3);
		sda_low = 1'b1; // Falling data with clock high
		q(3);
		scl = 1'b0;
		q(3);
	endtask
	task automatic stop();
		sda_low = 1'b1;
		q(3);
		scl = 1'b1;
		q(3);
		sda_low = 1'b0; // Rising data with clock high
		q(6);
	endtask
	// 12 cycles a bit, sampled mid-way through the high phase
	task automatic clk_bit(input logic b, output logic r);
		sda_low = ~b; // Data moves only while clock low
		q(3);
		scl = 1'b1;
		q(3);
		r = sda_line;
		q(3);
		scl = 1'b0;
		q(3);
	endtask
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
		clk_bit(1'b1, r); // Line let go for the answer
		ack = ~r;
	endtask
	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, r);
			d[i] = r;
		end
		clk_bit(last, r); // Low ack keeps the read going
	endtask
endmodule // bus_master

// ===== verification/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pot_i2c_pkg::*;
	logic       sys_clk, rst, shutdown_n, sda_oe, sda_out, scl, sda_low;
	logic       addr_strap_bit2, addr_strap_bit1, addr_strap_bit0;
	logic       pot_shutdown, nv_write_busy;
	logic [7:0] wiper0, wiper1;
	int         error_cnt, checks;
	// Pull-up: line high unless someone pulls it low
	wire        sda_line = ~(sda_low | (sda_oe & ~sda_out));
	// Short write cycle keeps the run brief
	pot_i2c_slave #(.NV_CYCLES(2000)) pot_i2c_slave_i (.sys_clk(sys_clk),
		.rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe(sda_oe), .addr_strap_bit2(addr_strap_bit2),
		.addr_strap_bit1(addr_strap_bit1), .addr_strap_bit0(addr_strap_bit0),
		.shutdown_n(shutdown_n), .pot_shutdown(pot_shutdown),
		.wiper0(wiper0), .wiper1(wiper1), .nv_write_busy(nv_write_busy));
	bus_master bus_master_i (.sys_clk(sys_clk), .sda_line(sda_line),
		.scl(scl), .sda_low(sda_low));
	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;
	// ****************************************
	// Shared helpers
	// ****************************************
	task automatic chk(input string what, input logic [23:0] exp,
		input logic [23:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [7:0] id(input logic rw);
		return {ID_PREFIX, addr_strap_bit2, addr_strap_bit1,
			addr_strap_bit0, rw};
	endfunction
	task automatic wr_seq(input logic [7:0] a, input logic [23:0] d,
		input int n);
		logic ack;
		bus_master_i.start();
		bus_master_i.wr_byte(id(1'b0), ack);
		chk("id ack", 24'h1, {23'h0, ack});
		bus_master_i.wr_byte(a, ack);
		chk("addr ack", 24'h1, {23'h0, ack});
		for (int i = 0; i < n; i++) begin
			bus_master_i.wr_byte(d[23-8*i -: 8], ack);
			chk("data ack", 24'h1, {23'h0, ack});
		end
		bus_master_i.stop();
	endtask
	task automatic rd_seq(input logic [7:0] a, input int n,
		output logic [23:0] got);
		logic       ack;
		logic [7:0] b;
		got = 24'h0;
		bus_master_i.start();
		bus_master_i.wr_byte(id(1'b0), ack);
		chk("rd id ack", 24'h1, {23'h0, ack});
		bus_master_i.wr_byte(a, ack);
		chk("rd addr ack", 24'h1, {23'h0, ack});
		bus_master_i.start();
		bus_master_i.wr_byte(id(1'b1), ack);
		chk("rd id2 ack", 24'h1, {23'h0, ack});
		for (int i = 0; i < n; i++) begin
			bus_master_i.rd_byte(i == n - 1, b);
			got[23-8*i -: 8] = b;
		end
		bus_master_i.stop();
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		logic ack;
		chk("sda_oe", 24'h0, {23'h0, sda_oe});
		chk("wipers", {8'h0, WIPER_RESET, WIPER_RESET}, {8'h0, wiper0, wiper1});
		chk("shutdown", 24'h0, {23'h0, pot_shutdown});
		chk("busy", 24'h0, {23'h0, nv_write_busy});
		// Start lands inside the power-up hold-off
		bus_master_i.start();
		bus_master_i.wr_byte(id(1'b0), ack);
		chk("early ack", 24'h0, {23'h0, ack});
		bus_master_i.stop();
	endtask
	task automatic t_bad_id();
		logic ack;
		for (int k = 0; k < 2; k++) begin
			bus_master_i.start();
			bus_master_i.wr_byte(id(1'b0) ^ (k ? 8'h08 : 8'h10), ack);
			chk("bad id ack", 24'h0, {23'h0, ack});
			bus_master_i.wr_byte(id(1'b0), ack);
			chk("no start ack", 24'h0, {23'h0, ack});
			bus_master_i.stop();
		end
	endtask
	task automatic t_write_read();
		logic [23:0] got;
		logic        ack;
		wr_seq(ADDR_ACR, 24'hc01122, 3);
		chk("wipers", 24'h1122, {8'h0, wiper0, wiper1});
		chk("busy", 24'h0, {23'h0, nv_write_busy});
		bus_master_i.wr_byte(id(1'b0), ack);
		chk("standby ack", 24'h0, {23'h0, ack});
		rd_seq(ADDR_ACR, 3, got);
		chk("read wrap", 24'hc01122, got);
		rd_seq(ADDR_RESERVED, 2, got);
		chk("reserved", 24'h00c000, got);
	endtask
	task automatic t_shutdown();
		logic [23:0] got;
		for (int k = 0; k < 4; k++) begin
			wr_seq(ADDR_ACR, {1'b1, k[0], 22'h0}, 1);
			shutdown_n = k[1];
			repeat (3) @(negedge sys_clk);
			chk("shutdown", {23'h0, ~(k[0] & k[1])}, {23'h0, pot_shutdown});
			rd_seq(ADDR_POT0, 1, got);
			chk("wiper kept", 24'h111111, {got[23:16], wiper0, wiper0});
		end
	endtask
	task automatic t_nv();
		logic [23:0] got;
		wr_seq(ADDR_ACR, 24'h400000, 1);
		wr_seq(ADDR_POT0, 24'h550000, 1);
		repeat (4) @(negedge sys_clk);
		chk("busy on", 24'h1, {23'h0, nv_write_busy});
		chk("copy", 24'h55, {16'h0, wiper0});
		wr_seq(ADDR_POT1, 24'h660000, 1);
		wr_seq(ADDR_ACR, 24'hc00000, 1);
		rd_seq(ADDR_ACR, 1, got);
		chk("acr busy", 24'h60, {16'h0, got[23:16]});
		for (int i = 0; i < 3000 && nv_write_busy !== 1'b0; i++)
			@(negedge sys_clk);
		chk("busy off", 24'h0, {23'h0, nv_write_busy});
		rd_seq(ADDR_ACR, 1, got);
		chk("acr kept", 24'h40, {16'h0, got[23:16]});
		rd_seq(ADDR_POT0, 2, got);
		chk("ivr read", {8'h55, NV_RESET, 8'h22}, {got[23:8], wiper1});
	endtask
	task automatic give_verdict();
		if (error_cnt == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		rst = 1'b1;
		shutdown_n = 1'b1;
		{addr_strap_bit2, addr_strap_bit1, addr_strap_bit0} = 3'b101;
		error_cnt = 0;
		checks = 0;
		repeat (4) @(negedge sys_clk);
		rst = 1'b0;
		t_reset();
		t_bad_id();
		t_write_read();
		t_shutdown();
		t_nv();
		give_verdict();
	end
	// Roughly four times the expected run
	initial begin
		repeat (40000) @(posedge sys_clk);
		error_cnt++;
		give_verdict();
	end
endmodule // tb_top
